// file: verilog/rtc_defs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef RTC_DEFS_SVH
`define RTC_DEFS_SVH

// Serial slave address, arbitrary value
`define RTC_I2C_ADDR 7'h32

// Timing
`define RTC_CLK_NS 10
`define RTC_IRQ_PULSE_NS 1000
`define RTC_IRQ_PULSE_CYC ((`RTC_IRQ_PULSE_NS) / (`RTC_CLK_NS))

// Register offsets
`define RTC_OFS_DEVICE_CONTROL 4'h0
`define RTC_OFS_IRQ_CONTROL_FLAGS 4'h1
`define RTC_OFS_SECONDS_AND_INTEGRITY 4'h2
`define RTC_OFS_MINUTES_COUNT 4'h3
`define RTC_OFS_HOURS_COUNT 4'h4
`define RTC_OFS_DAY_OF_MONTH 4'h5
`define RTC_OFS_DAY_OF_WEEK 4'h6
`define RTC_OFS_MONTH_AND_CENTURY 4'h7
`define RTC_OFS_YEAR_COUNT 4'h8
`define RTC_OFS_ALARM_MINUTE 4'h9
`define RTC_OFS_ALARM_HOUR 4'ha
`define RTC_OFS_ALARM_DAY 4'hb
`define RTC_OFS_ALARM_WEEKDAY 4'hc
`define RTC_OFS_SQUARE_WAVE_CONTROL 4'hd
`define RTC_OFS_COUNTDOWN_CONTROL 4'he
`define RTC_OFS_COUNTDOWN_VALUE 4'hf

// Field positions
`define RTC_BIT_EXT_TEST_CLOCK_SELECT 7
`define RTC_BIT_STOP 5
`define RTC_BIT_RESET_OVERRIDE_PERMIT 3
`define RTC_BIT_IRQ_PULSE_MODE 4
`define RTC_BIT_ALARM_FLAG 3
`define RTC_BIT_TIMER_FLAG 2
`define RTC_BIT_ALARM_IRQ_ENABLE 1
`define RTC_BIT_TIMER_IRQ_ENABLE 0
`define RTC_BIT_VOLTAGE_LOW_FLAG 7
`define RTC_BIT_ENABLE 7

// Implemented bits of the plain storage
`define RTC_MSK_DEVICE_CONTROL 8'ha8
`define RTC_MSK_IRQ_CONTROL_FLAGS 8'h13
`define RTC_MSK_SECONDS 8'h7f
`define RTC_MSK_MINUTES 8'h7f
`define RTC_MSK_HOURS 8'h3f
`define RTC_MSK_DAY_OF_MONTH 8'h3f
`define RTC_MSK_DAY_OF_WEEK 8'h07
`define RTC_MSK_MONTH_AND_CENTURY 8'h9f
`define RTC_MSK_YEAR 8'hff
`define RTC_MSK_ALARM_MINUTE 8'hff
`define RTC_MSK_ALARM_HOUR 8'hbf
`define RTC_MSK_ALARM_DAY 8'hbf
`define RTC_MSK_ALARM_WEEKDAY 8'h87
`define RTC_MSK_SQUARE_WAVE_CONTROL 8'h83
`define RTC_MSK_COUNTDOWN_CONTROL 8'h83
`define RTC_MSK_COUNTDOWN_VALUE 8'hff

// Reset values
`define RTC_RST_DEVICE_CONTROL 8'h08
`define RTC_RST_SQUARE_WAVE_CONTROL 8'h80
`define RTC_RST_OTHER 8'h00
`define RTC_RST_VOLTAGE_LOW_FLAG 1'b1

`endif

// file: verilog/rtc_pkg.sv
// Types used by the serial slave of the register bank
`default_nettype none
package rtc_pkg;
	typedef enum logic [3:0] {
		ST_IDLE,
		ST_DEV,
		ST_D_ACK,
		ST_REG,
		ST_WR,
		ST_W_ACK,
		ST_RD,
		ST_R_ACK,
		ST_WAIT
	} slave_state_t;
endpackage
`default_nettype wire

// file: verilog/rtc_i2c_slave.sv
// Two-wire serial slave with an auto-incrementing register pointer
`include "rtc_defs.svh"
`default_nettype none
module rtc_i2c_slave (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda_out,
	output logic o_sda_oe_n,
	output logic o_busy,
	output logic o_wr_stb,
	output logic [3:0] o_addr,
	output logic [7:0] o_wdata,
	input wire logic [7:0] i_rdata
);
	logic [1:0] scl_sync;
	logic [1:0] sda_sync;
	logic scl_q;
	logic sda_q;
	rtc_pkg::slave_state_t state;
	logic [3:0] bit_cnt;
	logic [7:0] shift;
	logic [7:0] tx;
	logic sda_low;
	logic rd_mode;
	logic after_data;
	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;

	// ==========================================
	// Pin synchronisers
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			scl_sync <= 2'h3;
			sda_sync <= 2'h3;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_sync <= {scl_sync[0], i_scl};
			sda_sync <= {sda_sync[0], i_sda};
			scl_q <= scl_sync[1];
			sda_q <= sda_sync[1];
		end
	end

	assign scl_rise = scl_sync[1] & ~scl_q;
	assign scl_fall = ~scl_sync[1] & scl_q;
	assign start_cond = scl_sync[1] & scl_q & sda_q & ~sda_sync[1];
	assign stop_cond = scl_sync[1] & scl_q & ~sda_q & sda_sync[1];

	// ==========================================
	// Byte engine; the pointer moves after every data byte
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			state <= rtc_pkg::ST_IDLE;
			bit_cnt <= 4'h0;
			shift <= 8'h00;
			tx <= 8'h00;
			sda_low <= 1'b0;
			rd_mode <= 1'b0;
			after_data <= 1'b0;
			o_addr <= 4'h0;
			o_wdata <= 8'h00;
			o_wr_stb <= 1'b0;
		end else begin
			o_wr_stb <= 1'b0;
			if (start_cond) begin
				state <= rtc_pkg::ST_DEV;
				bit_cnt <= 4'h0;
				sda_low <= 1'b0;
			end else if (stop_cond) begin
				state <= rtc_pkg::ST_IDLE;
				sda_low <= 1'b0;
			end else if (scl_rise) begin
				case (state)
					rtc_pkg::ST_DEV, rtc_pkg::ST_REG, rtc_pkg::ST_WR: begin
						shift <= {shift[6:0], sda_sync[1]};
						bit_cnt <= bit_cnt + 4'h1;
					end
					rtc_pkg::ST_RD: bit_cnt <= bit_cnt + 4'h1;
					// Master refused the byte: stay off the bus until the next start or stop
					rtc_pkg::ST_R_ACK: if (sda_sync[1]) state <= rtc_pkg::ST_WAIT;
					default: ;
				endcase
			end else if (scl_fall) begin
				case (state)
					rtc_pkg::ST_DEV: if (bit_cnt == 4'h8) begin
						if (shift[7:1] == `RTC_I2C_ADDR) begin
							state <= rtc_pkg::ST_D_ACK;
							sda_low <= 1'b1;
							rd_mode <= shift[0];
						end else begin
							state <= rtc_pkg::ST_WAIT;
						end
					end
					rtc_pkg::ST_D_ACK, rtc_pkg::ST_R_ACK: begin
						bit_cnt <= 4'h0;
						if (rd_mode) begin
							state <= rtc_pkg::ST_RD;
							tx <= {i_rdata[6:0], 1'b0};
							sda_low <= ~i_rdata[7];
							o_addr <= o_addr + 4'h1;
						end else begin
							state <= rtc_pkg::ST_REG;
							sda_low <= 1'b0;
						end
					end
					rtc_pkg::ST_REG: if (bit_cnt == 4'h8) begin
						o_addr <= shift[3:0];
						after_data <= 1'b0;
						state <= rtc_pkg::ST_W_ACK;
						sda_low <= 1'b1;
					end
					rtc_pkg::ST_WR: if (bit_cnt == 4'h8) begin
						o_wdata <= shift;
						o_wr_stb <= 1'b1;
						after_data <= 1'b1;
						state <= rtc_pkg::ST_W_ACK;
						sda_low <= 1'b1;
					end
					rtc_pkg::ST_W_ACK: begin
						sda_low <= 1'b0;
						bit_cnt <= 4'h0;
						state <= rtc_pkg::ST_WR;
						if (after_data) o_addr <= o_addr + 4'h1;
					end
					rtc_pkg::ST_RD: if (bit_cnt == 4'h8) begin
						sda_low <= 1'b0;
						state <= rtc_pkg::ST_R_ACK;
					end else begin
						sda_low <= ~tx[7];
						tx <= {tx[6:0], 1'b0};
					end
					default: ;
				endcase
			end
		end
	end

	assign o_busy = state != rtc_pkg::ST_IDLE;
	assign o_sda_out = 1'b0;
	assign o_sda_oe_n = ~sda_low;
endmodule
`default_nettype wire

// file: verilog/rtc_control_register_map.sv
// Register bank of the real-time clock with its serial slave and interrupt pin
`include "rtc_defs.svh"
`default_nettype none
module rtc_control_register_map (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda_out,
	output logic o_sda_oe_n,
	input wire logic i_alarm_event,
	input wire logic i_timer_event,
	input wire logic i_voltage_low,
	input wire logic [3:0] i_side_addr,
	input wire logic i_side_we,
	input wire logic [7:0] i_side_wdata,
	output logic [7:0] o_side_rdata,
	output logic o_time_freeze,
	output logic o_ext_test_clock_select,
	output logic o_divider_clear,
	output logic o_reset_override_permit,
	output logic o_square_wave_enable,
	output logic [1:0] o_square_wave_rate,
	output logic o_countdown_enable,
	output logic [1:0] o_countdown_source_select,
	output logic [7:0] o_countdown_value,
	output logic o_irq_out,
	output logic o_irq_oe_n
);
	logic [7:0] regs [16];
	logic alarm_flag;
	logic timer_flag;
	logic voltage_low_flag;
	logic host_wr;
	logic [3:0] host_addr;
	logic [7:0] host_wdata;
	logic [7:0] host_rdata;
	logic side_ok;
	logic [7:0] pulse_cnt;
	logic pulse_active;
	logic irq;
	logic next_irq;
	logic alarm_irq_enable;
	logic timer_irq_enable;
	logic irq_pulse_mode;

	// ==========================================
	// Per-register tables

	// Unused and reserved bits never reach storage
	function automatic logic [7:0] wr_mask(input logic [3:0] idx);
		case (idx)
			`RTC_OFS_DEVICE_CONTROL: wr_mask = `RTC_MSK_DEVICE_CONTROL;
			`RTC_OFS_IRQ_CONTROL_FLAGS: wr_mask = `RTC_MSK_IRQ_CONTROL_FLAGS;
			`RTC_OFS_SECONDS_AND_INTEGRITY: wr_mask = `RTC_MSK_SECONDS;
			`RTC_OFS_MINUTES_COUNT: wr_mask = `RTC_MSK_MINUTES;
			`RTC_OFS_HOURS_COUNT: wr_mask = `RTC_MSK_HOURS;
			`RTC_OFS_DAY_OF_MONTH: wr_mask = `RTC_MSK_DAY_OF_MONTH;
			`RTC_OFS_DAY_OF_WEEK: wr_mask = `RTC_MSK_DAY_OF_WEEK;
			`RTC_OFS_MONTH_AND_CENTURY: wr_mask = `RTC_MSK_MONTH_AND_CENTURY;
			`RTC_OFS_YEAR_COUNT: wr_mask = `RTC_MSK_YEAR;
			`RTC_OFS_ALARM_MINUTE: wr_mask = `RTC_MSK_ALARM_MINUTE;
			`RTC_OFS_ALARM_HOUR: wr_mask = `RTC_MSK_ALARM_HOUR;
			`RTC_OFS_ALARM_DAY: wr_mask = `RTC_MSK_ALARM_DAY;
			`RTC_OFS_ALARM_WEEKDAY: wr_mask = `RTC_MSK_ALARM_WEEKDAY;
			`RTC_OFS_SQUARE_WAVE_CONTROL: wr_mask = `RTC_MSK_SQUARE_WAVE_CONTROL;
			`RTC_OFS_COUNTDOWN_CONTROL: wr_mask = `RTC_MSK_COUNTDOWN_CONTROL;
			default: wr_mask = `RTC_MSK_COUNTDOWN_VALUE;
		endcase
	endfunction

	function automatic logic [7:0] rst_val(input logic [3:0] idx);
		case (idx)
			`RTC_OFS_DEVICE_CONTROL: rst_val = `RTC_RST_DEVICE_CONTROL;
			`RTC_OFS_SQUARE_WAVE_CONTROL: rst_val = `RTC_RST_SQUARE_WAVE_CONTROL;
			default: rst_val = `RTC_RST_OTHER;
		endcase
	endfunction

	// Only the unit digit is checked, and nothing in the day of week; tens are masked narrow except in the year, whose tens digit can pass 9
	function automatic logic bcd_ok(input logic [3:0] idx, input logic [7:0] d);
		if (idx == `RTC_OFS_DAY_OF_WEEK) begin
			bcd_ok = 1'b1;
		end else begin
			bcd_ok = d[3:0] <= 4'h9;
		end
	endfunction

	// Flags and the integrity bit live outside the plain storage
	function automatic logic [7:0] read_val(input logic [3:0] idx);
		read_val = regs[idx];
		if (idx == `RTC_OFS_IRQ_CONTROL_FLAGS) begin
			read_val[`RTC_BIT_ALARM_FLAG] = alarm_flag;
			read_val[`RTC_BIT_TIMER_FLAG] = timer_flag;
		end else if (idx == `RTC_OFS_SECONDS_AND_INTEGRITY) begin
			read_val[`RTC_BIT_VOLTAGE_LOW_FLAG] = voltage_low_flag;
		end
	endfunction

	// ==========================================
	// Serial slave

	rtc_i2c_slave u_slave (
		.i_clk(i_clk),
		.i_srst(i_srst),
		.i_scl(i_scl),
		.i_sda(i_sda),
		.o_sda_out(o_sda_out),
		.o_sda_oe_n(o_sda_oe_n),
		.o_busy(o_time_freeze),
		.o_wr_stb(host_wr),
		.o_addr(host_addr),
		.o_wdata(host_wdata),
		.i_rdata(host_rdata)
	);

	always_comb begin
		host_rdata = read_val(host_addr);
	end

	// ==========================================
	// Storage

	// Time engine writes are refused during a transfer so no carry lands mid-read
	always_comb begin
		side_ok = i_side_we && !o_time_freeze
			&& i_side_addr >= `RTC_OFS_SECONDS_AND_INTEGRITY
			&& i_side_addr <= `RTC_OFS_YEAR_COUNT
			&& bcd_ok(i_side_addr, i_side_wdata);
	end

	// Host wins over the time engine on a same-cycle clash
	for (genvar g = 0; g < 16; g++) begin : g_reg
		always_ff @(posedge i_clk) begin
			if (i_srst) begin
				regs[g] <= rst_val(4'(g));
			end else if (host_wr && host_addr == 4'(g)) begin
				regs[g] <= host_wdata & wr_mask(4'(g));
			end else if (side_ok && i_side_addr == 4'(g)) begin
				regs[g] <= i_side_wdata & wr_mask(4'(g));
			end
		end
	end

	always_ff @(posedge i_clk) begin
		o_side_rdata <= i_srst ? 8'h00 : read_val(i_side_addr);
	end

	// ==========================================
	// Sticky flags; a set in the clearing cycle wins

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			alarm_flag <= 1'b0;
		end else if (i_alarm_event) begin
			alarm_flag <= 1'b1;
		end else if (host_wr && host_addr == `RTC_OFS_IRQ_CONTROL_FLAGS) begin
			alarm_flag <= alarm_flag & host_wdata[`RTC_BIT_ALARM_FLAG];
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			timer_flag <= 1'b0;
		end else if (i_timer_event) begin
			timer_flag <= 1'b1;
		end else if (host_wr && host_addr == `RTC_OFS_IRQ_CONTROL_FLAGS) begin
			timer_flag <= timer_flag & host_wdata[`RTC_BIT_TIMER_FLAG];
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			voltage_low_flag <= `RTC_RST_VOLTAGE_LOW_FLAG;
		end else if (i_voltage_low) begin
			voltage_low_flag <= 1'b1;
		end else if (host_wr && host_addr == `RTC_OFS_SECONDS_AND_INTEGRITY) begin
			voltage_low_flag <= host_wdata[`RTC_BIT_VOLTAGE_LOW_FLAG];
		end
	end

	// ==========================================
	// Control outputs

	assign o_ext_test_clock_select =
		regs[`RTC_OFS_DEVICE_CONTROL][`RTC_BIT_EXT_TEST_CLOCK_SELECT];
	// Divider clears itself asynchronously on this level; square wave keeps running
	assign o_divider_clear = regs[`RTC_OFS_DEVICE_CONTROL][`RTC_BIT_STOP];
	assign o_reset_override_permit =
		regs[`RTC_OFS_DEVICE_CONTROL][`RTC_BIT_RESET_OVERRIDE_PERMIT];
	assign o_square_wave_enable = regs[`RTC_OFS_SQUARE_WAVE_CONTROL][`RTC_BIT_ENABLE];
	assign o_square_wave_rate = regs[`RTC_OFS_SQUARE_WAVE_CONTROL][1:0];
	assign o_countdown_enable = regs[`RTC_OFS_COUNTDOWN_CONTROL][`RTC_BIT_ENABLE];
	assign o_countdown_source_select = regs[`RTC_OFS_COUNTDOWN_CONTROL][1:0];
	assign o_countdown_value = regs[`RTC_OFS_COUNTDOWN_VALUE];

	assign alarm_irq_enable =
		regs[`RTC_OFS_IRQ_CONTROL_FLAGS][`RTC_BIT_ALARM_IRQ_ENABLE];
	assign timer_irq_enable =
		regs[`RTC_OFS_IRQ_CONTROL_FLAGS][`RTC_BIT_TIMER_IRQ_ENABLE];
	assign irq_pulse_mode = regs[`RTC_OFS_IRQ_CONTROL_FLAGS][`RTC_BIT_IRQ_PULSE_MODE];

	// ==========================================
	// Interrupt pin

	// Fixed pulse width; the countdown's own source clock is not seen here
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			pulse_cnt <= 8'h00;
		end else if (i_timer_event) begin
			pulse_cnt <= 8'(`RTC_IRQ_PULSE_CYC);
		end else if (pulse_cnt != 8'h00) begin
			pulse_cnt <= pulse_cnt - 8'h01;
		end
	end

	assign pulse_active = pulse_cnt != 8'h00;

	always_comb begin
		next_irq = (alarm_flag && alarm_irq_enable)
			|| (timer_irq_enable && (irq_pulse_mode ? pulse_active : timer_flag));
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			irq <= 1'b0;
		end else begin
			irq <= next_irq;
		end
	end

	// Open drain: only ever pulls low
	assign o_irq_out = 1'b0;
	assign o_irq_oe_n = ~irq;

	// ==========================================
	// Checks

	default clocking cb @(posedge i_clk);
	endclocking

	default disable iff (i_srst);

	sequence s_flag_write;
		host_wr && host_addr == `RTC_OFS_IRQ_CONTROL_FLAGS;
	endsequence

	sequence s_pulse_arm;
		i_timer_event && irq_pulse_mode && timer_irq_enable;
	endsequence

	sequence s_side_blocked;
		o_time_freeze && i_side_we && i_side_addr == `RTC_OFS_MINUTES_COUNT
			&& !(host_wr && host_addr == `RTC_OFS_MINUTES_COUNT);
	endsequence

	AST_RESET_DEFAULTS: assert property (
		$past(i_srst) |-> regs[`RTC_OFS_DEVICE_CONTROL] == `RTC_RST_DEVICE_CONTROL
			&& !alarm_flag && !timer_flag && o_irq_oe_n)
		else $error("Control defaults wrong after reset");

	// A host clear right after the event may legally drop the flag again
	AST_ALARM_SET: assert property (
		i_alarm_event ##1 !(host_wr && host_addr == `RTC_OFS_IRQ_CONTROL_FLAGS) |-> alarm_flag [*2])
		else $error("Alarm flag not set and held");

	AST_TIMER_SET: assert property (
		i_timer_event |=> timer_flag)
		else $error("Timer flag not set by countdown end");

	AST_ALARM_CLEAR: assert property (
		s_flag_write ##0 (!host_wdata[`RTC_BIT_ALARM_FLAG] && !i_alarm_event) |=> !alarm_flag)
		else $error("Alarm flag not cleared by zero write");

	AST_ALARM_KEEP: assert property (
		s_flag_write ##0 (host_wdata[`RTC_BIT_ALARM_FLAG] && alarm_flag) |=> alarm_flag)
		else $error("Alarm flag lost on one write");

	AST_TIMER_AND: assert property (
		s_flag_write ##0 !i_timer_event
			|=> timer_flag == ($past(timer_flag) && $past(host_wdata[`RTC_BIT_TIMER_FLAG])))
		else $error("Timer flag write is not an AND");

	AST_TIMER_LEVEL: assert property (
		timer_flag && timer_irq_enable && !irq_pulse_mode |=> !o_irq_oe_n)
		else $error("Level interrupt missing for timer flag");

	AST_TIMER_PULSE: assert property (
		s_pulse_arm |-> ##2 (!o_irq_oe_n) [*8])
		else $error("Timer interrupt pulse too short");

	AST_ALARM_HOLD: assert property (
		alarm_flag && alarm_irq_enable |=> !o_irq_oe_n)
		else $error("Alarm interrupt not held");

	AST_IRQ_IDLE: assert property (
		!(alarm_flag && alarm_irq_enable) && !(timer_irq_enable && (timer_flag || pulse_active))
			|=> o_irq_oe_n)
		else $error("Interrupt without enabled cause");

	AST_FREEZE: assert property (
		s_side_blocked |=> $stable(regs[`RTC_OFS_MINUTES_COUNT]))
		else $error("Counter changed during a transfer");

	AST_MASKED: assert property (
		host_wr && host_addr == `RTC_OFS_DEVICE_CONTROL
			|=> (regs[`RTC_OFS_DEVICE_CONTROL] & ~`RTC_MSK_DEVICE_CONTROL) == 8'h00)
		else $error("Reserved control bit stored");

	AST_CTRL_OUT: assert property (
		host_wr && host_addr == `RTC_OFS_DEVICE_CONTROL
			|=> o_ext_test_clock_select == $past(host_wdata[`RTC_BIT_EXT_TEST_CLOCK_SELECT])
			&& o_divider_clear == $past(host_wdata[`RTC_BIT_STOP])
			&& o_reset_override_permit == $past(host_wdata[`RTC_BIT_RESET_OVERRIDE_PERMIT]))
		else $error("Control output does not follow written bit");

	AST_IRQ_ENABLES: assert property (
		s_flag_write |=> alarm_irq_enable == $past(host_wdata[`RTC_BIT_ALARM_IRQ_ENABLE])
			&& timer_irq_enable == $past(host_wdata[`RTC_BIT_TIMER_IRQ_ENABLE]))
		else $error("Interrupt enable does not follow written bit");

	AST_RESET_OUTPUTS: assert property (
		$past(i_srst) |-> o_sda_oe_n && !o_time_freeze && o_square_wave_enable
			&& voltage_low_flag && o_side_rdata == 8'h00)
		else $error("Pin or status defaults wrong after reset");
endmodule
`default_nettype wire

// file: sim/rtc_host_model.sv
// Two-wire bus master model standing in for the host controller
`include "rtc_defs.svh"
`default_nettype none
module rtc_host_model (
	input wire logic i_clk,
	input wire logic i_sda,
	output var logic o_scl,
	output var logic o_sda_pull
);
	timeunit 1ns;
	timeprecision 1ps;

	int nacks;

	initial begin
		o_scl = 1'b1;
		o_sda_pull = 1'b0;
		nacks = 0;
	end

	// ==========================================
	// Bit level
	// ==========================================
	// Eight cycles a phase, twice the slave's minimum
	task automatic half();
		repeat (8) @(posedge i_clk);
	endtask

	// Data moves two cycles after the clock fall, never with it
	task automatic put_bit(input logic b);
		repeat (2) @(posedge i_clk);
		o_sda_pull <= ~b;
		half();
		o_scl <= 1'b1;
		half();
		o_scl <= 1'b0;
	endtask

	task automatic get_bit(output logic b);
		repeat (2) @(posedge i_clk);
		o_sda_pull <= 1'b0;
		half();
		o_scl <= 1'b1;
		repeat (4) @(posedge i_clk);
		b = i_sda;
		repeat (4) @(posedge i_clk);
		o_scl <= 1'b0;
	endtask

	task automatic start();
		repeat (2) @(posedge i_clk);
		o_sda_pull <= 1'b0;
		half();
		o_scl <= 1'b1;
		half();
		o_sda_pull <= 1'b1;
		half();
		o_scl <= 1'b0;
	endtask

	task automatic stop();
		repeat (2) @(posedge i_clk);
		o_sda_pull <= 1'b1;
		half();
		o_scl <= 1'b1;
		half();
		o_sda_pull <= 1'b0;
		half();
	endtask

	// ==========================================
	// Byte and transfer level
	// ==========================================
	task automatic put_byte(input logic [7:0] b);
		logic a;
		for (int i = 7; i >= 0; i--) begin
			put_bit(b[i]);
		end
		get_bit(a);
		if (a !== 1'b0) begin
			nacks++;
		end
	endtask

	task automatic get_byte(input logic last, output logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			get_bit(b[i]);
		end
		put_bit(last);
	endtask

	task automatic write_seq(input logic [3:0] ptr, input logic [7:0] d[$]);
		start();
		put_byte({`RTC_I2C_ADDR, 1'b0});
		put_byte({4'h0, ptr});
		foreach (d[i]) begin
			put_byte(d[i]);
		end
		stop();
	endtask

	// Pointer set by a write, then a repeated start turns the bus round
	task automatic read_seq(input logic [3:0] ptr, input int n, output logic [7:0] q[$]);
		logic [7:0] b;
		q = {};
		start();
		put_byte({`RTC_I2C_ADDR, 1'b0});
		put_byte({4'h0, ptr});
		start();
		put_byte({`RTC_I2C_ADDR, 1'b1});
		for (int i = 0; i < n; i++) begin
			get_byte(i == n - 1, b);
			q.push_back(b);
		end
		stop();
	endtask
endmodule
`default_nettype wire

// file: sim/test_rtc_control_register_map.sv
// Self-checking bench for the real-time clock register bank
`include "rtc_defs.svh"
`default_nettype none
module test_rtc_control_register_map;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk, srst, scl, sda_pull, sda_line, sda_out, sda_oe_n;
	logic alarm_ev, timer_ev, vlow, side_we, freeze, ext_test, div_clr, permit;
	logic sq_en, cd_en, irq_out, irq_oe_n;
	logic [1:0] sq_rate, cd_src;
	logic [3:0] side_addr;
	logic [7:0] side_wdata, side_rdata, cd_val, v;
	logic [7:0] q[$];
	logic [7:0] d[$];
	logic [7:0] msk [16] = '{8'ha8, 8'h1f, 8'hff, 8'h7f, 8'h3f, 8'h3f, 8'h07, 8'h9f,
		8'hff, 8'hff, 8'hbf, 8'hbf, 8'h87, 8'h83, 8'h83, 8'hff};
	int fails, checks_done;

	// Pull-up: low if either party pulls
	assign sda_line = ~sda_pull & (sda_oe_n | sda_out);

	rtc_control_register_map uut (.i_clk(clk), .i_srst(srst), .i_scl(scl), .i_sda(sda_line),
		.o_sda_out(sda_out), .o_sda_oe_n(sda_oe_n), .i_alarm_event(alarm_ev), .i_timer_event(timer_ev),
		.i_voltage_low(vlow), .i_side_addr(side_addr), .i_side_we(side_we), .i_side_wdata(side_wdata),
		.o_side_rdata(side_rdata), .o_time_freeze(freeze), .o_ext_test_clock_select(ext_test),
		.o_divider_clear(div_clr), .o_reset_override_permit(permit), .o_square_wave_enable(sq_en),
		.o_square_wave_rate(sq_rate), .o_countdown_enable(cd_en), .o_countdown_source_select(cd_src),
		.o_countdown_value(cd_val), .o_irq_out(irq_out), .o_irq_oe_n(irq_oe_n));

	rtc_host_model host (.i_clk(clk), .i_sda(sda_line), .o_scl(scl), .o_sda_pull(sda_pull));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ==========================================
	// Helpers
	// ==========================================
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] val);
		d = {val};
		host.write_seq(a, d);
	endtask

	task automatic rd(input logic [3:0] a);
		host.read_seq(a, 1, q);
		v = q[0] & msk[a];
	endtask

	task automatic side_wr(input logic [3:0] a, input logic [7:0] val);
		@(posedge clk);
		side_addr <= a;
		side_we <= 1'b1;
		side_wdata <= val;
		@(posedge clk);
		side_we <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
	endtask

	task automatic pulse(input logic alarm);
		@(posedge clk);
		alarm_ev <= alarm;
		timer_ev <= ~alarm;
		@(posedge clk);
		alarm_ev <= 1'b0;
		timer_ev <= 1'b0;
	endtask

	task automatic wait_irq(input logic lvl);
		int n;
		n = 0;
		while (irq_oe_n !== lvl && n < 6) begin
			@(posedge clk);
			#1;
			n++;
		end
		check({6'h00, irq_out, irq_oe_n}, {7'h00, lvl});
	endtask

	// ==========================================
	// Scenarios
	// ==========================================
	task automatic test_reset();
		check({ext_test, div_clr, permit, sq_en, cd_en, freeze, sq_rate}, 8'h30);
		check({7'h00, irq_oe_n}, 8'h01);
		host.read_seq(4'h0, 16, q);
		for (int i = 0; i < 16; i++) begin
			check(q[i] & msk[i], (i == 0) ? 8'h08 : (i == 2 || i == 13) ? 8'h80 : 8'h00);
		end
	endtask

	task automatic test_control();
		wr(4'h0, 8'ha8);
		check({5'h00, ext_test, div_clr, permit}, 8'h07);
		rd(4'h0);
		check(v, 8'ha8);
		wr(4'h0, 8'h00);
		check({5'h00, ext_test, div_clr, permit}, 8'h00);
		wr(4'h3, 8'hd9);
		rd(4'h3);
		check(v, 8'h59);
	endtask

	task automatic test_burst();
		d = {8'h81, 8'h7b, 8'h00};
		host.write_seq(4'he, d);
		check({cd_en, cd_src, cd_val[4:0]}, {1'b1, 2'b01, 5'h1b});
		check(cd_val, 8'h7b);
		host.read_seq(4'he, 2, q);
		check(q[0] & 8'h83, 8'h81);
		check(q[1], 8'h7b);
		wr(4'hd, 8'h7f);
		check({5'h00, sq_en, sq_rate}, 8'h03);
		// Foreign address: the slave must stay silent until stop
		host.start();
		host.put_byte(8'h10);
		host.stop();
		check(host.nacks[7:0], 8'h01);
	endtask

	// Side write during an open transfer must be dropped
	task automatic test_freeze();
		check({7'h00, freeze}, 8'h00);
		side_wr(4'h3, 8'h25);
		check(side_rdata, 8'h25);
		side_wr(4'h3, 8'h3a);
		check(side_rdata, 8'h25);
		fork
			host.read_seq(4'h3, 1, q);
			begin
				repeat (40) @(posedge clk);
				#1;
				check({7'h00, freeze}, 8'h01);
				side_wr(4'h3, 8'h47);
			end
		join
		check(q[0] & 8'h7f, 8'h25);
		side_wr(4'h3, 8'h47);
		check(side_rdata, 8'h47);
	endtask

	task automatic test_flags();
		wr(4'h1, 8'h00);
		pulse(1'b1);
		pulse(1'b0);
		repeat (4) @(posedge clk);
		#1;
		check({7'h00, irq_oe_n}, 8'h01);
		rd(4'h1);
		check(v, 8'h0c);
		wr(4'h1, 8'h08);
		rd(4'h1);
		check(v, 8'h08);
		wr(4'h1, 8'h0a);
		wait_irq(1'b0);
		wr(4'h1, 8'h00);
		wait_irq(1'b1);
		wr(4'h1, 8'h01);
		pulse(1'b0);
		wait_irq(1'b0);
		repeat (150) @(posedge clk);
		wr(4'h1, 8'h05);
		check({7'h00, irq_oe_n}, 8'h00);
		wr(4'h1, 8'h01);
		wait_irq(1'b1);
		wr(4'h1, 8'h11);
		pulse(1'b0);
		wait_irq(1'b0);
		repeat (50) @(posedge clk);
		check({7'h00, irq_oe_n}, 8'h00);
		repeat (60) @(posedge clk);
		check({7'h00, irq_oe_n}, 8'h01);
		rd(4'h1);
		check(v, 8'h15);
		wr(4'h1, 8'h13);
		pulse(1'b1);
		wait_irq(1'b0);
		repeat (150) @(posedge clk);
		check({7'h00, irq_oe_n}, 8'h00);
		wr(4'h1, 8'h10);
		wait_irq(1'b1);
	endtask

	task automatic tally_and_finish();
		if (fails == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	initial begin
		fails = 0;
		checks_done = 0;
		srst = 1'b1;
		alarm_ev = 1'b0;
		timer_ev = 1'b0;
		vlow = 1'b0;
		side_addr = 4'h0;
		side_we = 1'b0;
		side_wdata = 8'h00;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		repeat (4) @(posedge clk);
		#1;
		test_reset();
		test_control();
		test_burst();
		test_freeze();
		test_flags();
		check(host.nacks[7:0], 8'h01);
		tally_and_finish();
	end
endmodule
`default_nettype wire
